// *** hdl/ppc_top.sv ***
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ppc_top
    import ppc_pkg::*;
#(
    parameter int M_PINS = 6,
    parameter int P_PINS = 8
) (
    // Clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Avalon-MM slave
    input wire logic [PPC_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic [1:0] avs_response_out,
    output logic avs_waitrequest_out,
    // First port pin control
    input wire logic [5:0] first_port_direction_in,
    input wire logic [5:0] first_port_data_in,
    input wire logic [5:0] periph_force_en_in,
    input wire logic [5:0] periph_force_dir_in,
    output ppc_m_pad_t first_port_pad_out,
    // Second port pins
    input wire logic [7:0] second_port_pin_in,
    output ppc_p_pad_t second_port_pad_out
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (M_PINS != 6 || P_PINS != 8) begin : g_bad_width
        $error("ppc_top supports six first-port and eight second-port pins only");
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic ppc_sel_t decode_addr(input logic [PPC_ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = {2'h0, addr[PPC_ADDR_W-1:PPC_ADDR_SHIFT]};
        if (addr[PPC_ADDR_SHIFT-1:0] != 2'h0) begin
            decode_addr = PPC_SEL_NONE;
        end else if (idx == PPC_IDX_M_PULL_EN) begin
            decode_addr = PPC_SEL_M_PULL_EN;
        end else if (idx == PPC_IDX_M_PULL_POL) begin
            decode_addr = PPC_SEL_M_PULL_POL;
        end else if (idx == PPC_IDX_M_OPEN_DRAIN) begin
            decode_addr = PPC_SEL_M_OPEN_DRAIN;
        end else if (idx == PPC_IDX_P_LATCH) begin
            decode_addr = PPC_SEL_P_LATCH;
        end else if (idx == PPC_IDX_P_LEVELS) begin
            decode_addr = PPC_SEL_P_LEVELS;
        end else if (idx == PPC_IDX_P_DIR) begin
            decode_addr = PPC_SEL_P_DIR;
        end else if (idx == PPC_IDX_P_DRIVE) begin
            decode_addr = PPC_SEL_P_DRIVE;
        end else begin
            decode_addr = PPC_SEL_NONE;
        end
    endfunction : decode_addr

    // ----------------------------------------
    // Mixed readback of latch and pins
    // ----------------------------------------
    function automatic logic [7:0] latch_or_pin(input logic [7:0] dir, input logic [7:0] latch,
                                               input logic [7:0] pin);
        latch_or_pin = (dir & latch) | (~dir & pin);
    endfunction : latch_or_pin

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [5:0] first_port_pull_enable;
    logic [5:0] first_port_pull_polarity;
    logic [5:0] first_port_open_drain;
    logic [7:0] second_port_output_latch;
    logic [7:0] second_port_direction;
    logic [7:0] second_port_drive_strength;
    logic [7:0] second_port_pin_levels;
    ppc_bus_state_t bus_state;
    ppc_bus_state_t next_bus_state;

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    logic bus_req;
    logic bus_commit;
    logic wr_commit;
    logic lane0;
    ppc_sel_t sel;
    logic [7:0] wr_byte;

    assign bus_req = (avs_read_in | avs_write_in) & ce_in;
    assign sel = decode_addr(avs_address_in);
    assign lane0 = avs_byteenable_in[0];
    assign wr_byte = avs_writedata_in[7:0];
    // One wait cycle; data and answer settle in it
    assign bus_commit = bus_req & (bus_state == PPC_BUS_ANSWER);
    assign wr_commit = bus_commit & avs_write_in & lane0;
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~bus_commit;

    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            PPC_BUS_IDLE: begin
                if (bus_req) begin
                    next_bus_state = PPC_BUS_ANSWER;
                end
            end
            PPC_BUS_ANSWER: begin
                next_bus_state = PPC_BUS_IDLE;
            end
            default: begin
                next_bus_state = PPC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_state <= PPC_BUS_IDLE;
        end else if (ce_in) begin
            bus_state <= next_bus_state;
        end
    end

    // ----------------------------------------
    // First port configuration
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            first_port_pull_enable <= PPC_RST_M_PULL_EN[5:0];
        end else if (ce_in && wr_commit && sel == PPC_SEL_M_PULL_EN) begin
            first_port_pull_enable <= wr_byte[5:0];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            first_port_pull_polarity <= PPC_RST_M_PULL_POL[5:0];
        end else if (ce_in && wr_commit && sel == PPC_SEL_M_PULL_POL) begin
            first_port_pull_polarity <= wr_byte[5:0];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            first_port_open_drain <= PPC_RST_M_OPEN_DRAIN[5:0];
        end else if (ce_in && wr_commit && sel == PPC_SEL_M_OPEN_DRAIN) begin
            first_port_open_drain <= wr_byte[5:0];
        end
    end

    // ----------------------------------------
    // Second port configuration
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            second_port_output_latch <= PPC_RST_P_LATCH;
        end else if (ce_in && wr_commit && sel == PPC_SEL_P_LATCH) begin
            second_port_output_latch <= wr_byte;
        end
    end

    // Levels register has no write path at all
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            second_port_direction <= PPC_RST_P_DIR;
        end else if (ce_in && wr_commit && sel == PPC_SEL_P_DIR) begin
            second_port_direction <= wr_byte;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            second_port_drive_strength <= PPC_RST_P_DRIVE;
        end else if (ce_in && wr_commit && sel == PPC_SEL_P_DRIVE) begin
            second_port_drive_strength <= wr_byte;
        end
    end

    // ----------------------------------------
    // Pin level synchroniser
    // ----------------------------------------
    // Pins are sampled two cycles late, hence the settling window
    ppc_sync #(
        .WIDTH(8)
    ) u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .async_in(second_port_pin_in),
        .sync_out(second_port_pin_levels)
    );

    // ----------------------------------------
    // Read data and answer
    // ----------------------------------------
    logic [7:0] rd_byte;
    logic rd_hit;

    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (sel)
            PPC_SEL_M_PULL_EN: begin
                rd_byte = {2'h0, first_port_pull_enable};
            end
            PPC_SEL_M_PULL_POL: begin
                rd_byte = {2'h0, first_port_pull_polarity};
            end
            PPC_SEL_M_OPEN_DRAIN: begin
                rd_byte = {2'h0, first_port_open_drain};
            end
            PPC_SEL_P_LATCH: begin
                rd_byte = latch_or_pin(second_port_direction, second_port_output_latch,
                                       second_port_pin_levels);
            end
            PPC_SEL_P_LEVELS: begin
                rd_byte = second_port_pin_levels;
            end
            PPC_SEL_P_DIR: begin
                rd_byte = second_port_direction;
            end
            PPC_SEL_P_DRIVE: begin
                rd_byte = second_port_drive_strength;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Loaded in the wait cycle so data stands at the accepting edge
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (ce_in && bus_req && bus_state == PPC_BUS_IDLE) begin
            avs_readdata_out <= avs_read_in ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_response_out <= PPC_RESP_OKAY;
        end else if (ce_in && bus_req && bus_state == PPC_BUS_IDLE) begin
            avs_response_out <= rd_hit ? PPC_RESP_OKAY : PPC_RESP_DECODE_ERR;
        end
    end

    // ----------------------------------------
    // First port pad control
    // ----------------------------------------
    logic [5:0] m_dir;
    logic [5:0] m_active_drive;

    // Peripheral force wins while enabled, then the direction bits return
    assign m_dir = (periph_force_en_in & periph_force_dir_in) |
                   (~periph_force_en_in & first_port_direction_in);
    // Open drain: buffer enabled only to pull low
    assign m_active_drive = m_dir & (~first_port_open_drain | ~first_port_data_in);

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            first_port_pad_out <= '0;
        end else if (ce_in) begin
            first_port_pad_out.drive <= first_port_data_in & ~first_port_open_drain;
            first_port_pad_out.oe <= m_active_drive;
            first_port_pad_out.pull_up <= first_port_pull_enable & ~first_port_pull_polarity &
                                          (~m_dir | first_port_open_drain);
            first_port_pad_out.pull_down <= first_port_pull_enable & first_port_pull_polarity &
                                            ~m_dir;
        end
    end

    // ----------------------------------------
    // Second port pad control
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            second_port_pad_out <= '0;
        end else if (ce_in) begin
            second_port_pad_out.drive <= second_port_output_latch;
            second_port_pad_out.oe <= second_port_direction;
            second_port_pad_out.reduced <= second_port_drive_strength &
                                           second_port_direction;
        end
    end

endmodule : ppc_top
`default_nettype wire

// *** hdl/ppc_pkg.sv ***
// What this block does
// - A first-port pull enable turns the pull device on for an input pin, or for an open-drain pin with pull-up polarity, never for a push-pull output.
// - The first-port pull enables leave reset set, with pull-up polarity selected.
// - Polarity 0 gives a pull-up for input or open-drain pins, polarity 1 a pull-down for input pins only.
// - A set open-drain bit lets the first-port buffer drive low only, a clear bit gives push-pull, inputs unaffected.
// - The second-port data register reads the latch where direction is 1 and the pin where it is 0, writes always taken.
// - The second-port input register is read-only and a write to it changes nothing.
// - The input register always returns the sampled pin levels whatever the direction.
// - Second-port direction bits make a pin an input at 0 and an output at 1, readable and writable at any time.
// - After a direction change, data and input reads may need two bus cycles before they are correct.
// - A reduced-drive bit selects about one-third drive at 1 and full drive at 0, ignored for inputs.
// - First-port direction bits regain control of a pin once the peripheral forcing it lets go.
package ppc_pkg;

    // ----------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------
    localparam logic [7:0] PPC_IDX_M_PULL_EN = 8'h14;
    localparam logic [7:0] PPC_IDX_M_PULL_POL = 8'h15;
    localparam logic [7:0] PPC_IDX_M_OPEN_DRAIN = 8'h16;
    localparam logic [7:0] PPC_IDX_P_LATCH = 8'h18;
    localparam logic [7:0] PPC_IDX_P_LEVELS = 8'h19;
    localparam logic [7:0] PPC_IDX_P_DIR = 8'h1a;
    localparam logic [7:0] PPC_IDX_P_DRIVE = 8'h1b;
    localparam int PPC_ADDR_W = 8;
    localparam int PPC_ADDR_SHIFT = 2;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] PPC_RST_M_PULL_EN = 8'hff;
    localparam logic [7:0] PPC_RST_M_PULL_POL = 8'h00;
    localparam logic [7:0] PPC_RST_M_OPEN_DRAIN = 8'h00;
    localparam logic [7:0] PPC_RST_P_LATCH = 8'h00;
    localparam logic [7:0] PPC_RST_P_DIR = 8'h00;
    localparam logic [7:0] PPC_RST_P_DRIVE = 8'h00;

    // ----------------------------------------
    // Bus answer and timing
    // ----------------------------------------
    localparam logic [1:0] PPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PPC_RESP_DECODE_ERR = 2'h3;
    localparam int PPC_SYNC_STAGES = 2;
    localparam int PPC_DIR_SETTLE_CYCLES = 2;

    // ----------------------------------------
    // Decode result
    // ----------------------------------------
    typedef enum logic [2:0] {
        PPC_SEL_NONE = 3'b000,
        PPC_SEL_M_PULL_EN = 3'b001,
        PPC_SEL_M_PULL_POL = 3'b010,
        PPC_SEL_M_OPEN_DRAIN = 3'b011,
        PPC_SEL_P_LATCH = 3'b100,
        PPC_SEL_P_LEVELS = 3'b101,
        PPC_SEL_P_DIR = 3'b110,
        PPC_SEL_P_DRIVE = 3'b111
    } ppc_sel_t;

    // ----------------------------------------
    // Bus handshake states
    // ----------------------------------------
    typedef enum logic [0:0] {
        PPC_BUS_IDLE = 1'b0,
        PPC_BUS_ANSWER = 1'b1
    } ppc_bus_state_t;

    // ----------------------------------------
    // Pad control bundles
    // ----------------------------------------
    typedef struct packed {
        logic [5:0] drive;
        logic [5:0] oe;
        logic [5:0] pull_up;
        logic [5:0] pull_down;
    } ppc_m_pad_t;

    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] oe;
        logic [7:0] reduced;
    } ppc_p_pad_t;

endpackage : ppc_pkg

// *** hdl/ppc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppc_sync
    import ppc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] stage_two;

    // ----------------------------------------
    // Two flops, first read only by second
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_one <= '0;
            stage_two <= '0;
        end else if (ce_in) begin
            stage_one <= async_in;
            stage_two <= stage_one;
        end
    end

    assign sync_out = stage_two;

endmodule : ppc_sync
`default_nettype wire

// *** sim/ppc_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Second-port pins outside the package
// ----------------------------------------
module ppc_pin_model
    import ppc_pkg::*;
(
    // Pad controls from the block
    input wire ppc_p_pad_t pad_in,
    // Outside world
    input wire logic [7:0] ext_level_in,
    input wire logic [7:0] short_low_in,
    output logic [7:0] pin_out
);
    // Driven bits follow the latch, others the outside driver
    // A short to ground wins over our own drive
    always_comb begin
        pin_out = ((pad_in.oe & pad_in.drive) | (~pad_in.oe & ext_level_in)) & ~short_low_in;
    end
endmodule : ppc_pin_model
`default_nettype wire

// *** sim/ppc_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module ppc_monitor
    import ppc_pkg::*;
#(
    parameter int M_PINS = 6,
    parameter int P_PINS = 8
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Bus
    input wire logic [PPC_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic [1:0] avs_response_out,
    input wire logic avs_waitrequest_out,
    // Pins
    input wire logic [5:0] first_port_direction_in,
    input wire logic [5:0] first_port_data_in,
    input wire logic [5:0] periph_force_en_in,
    input wire logic [5:0] periph_force_dir_in,
    input wire ppc_m_pad_t first_port_pad_out,
    input wire ppc_p_pad_t second_port_pad_out
);
    logic [5:0] dir_q;
    logic [5:0] data_q;
    logic req;
    logic done;
    assign req = avs_read_in | avs_write_in;
    assign done = req & ~avs_waitrequest_out;
    // Pads are registered, so compare against last cycle's causes
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dir_q <= 6'h00;
            data_q <= 6'h00;
        end else if (ce_in) begin
            dir_q <= (periph_force_en_in & periph_force_dir_in)
                | (~periph_force_en_in & first_port_direction_in);
            data_q <= first_port_data_in;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    property p_pull_one_way;
        (first_port_pad_out.pull_up & first_port_pad_out.pull_down) == 6'h00;
    endproperty
    property p_pull_down_input;
        (first_port_pad_out.pull_down & dir_q) == 6'h00;
    endproperty
    property p_no_pull_push_pull;
        ((first_port_pad_out.pull_up | first_port_pad_out.pull_down) & dir_q
            & first_port_pad_out.drive) == 6'h00;
    endproperty
    property p_drive_from_data;
        (first_port_pad_out.drive & ~data_q) == 6'h00;
    endproperty
    property p_oe_output_only;
        (first_port_pad_out.oe & ~dir_q) == 6'h00;
    endproperty
    property p_reduced_output;
        (second_port_pad_out.reduced & ~second_port_pad_out.oe) == 8'h00;
    endproperty
    property p_one_wait;
        (req && avs_waitrequest_out && ce_in) |=> !avs_waitrequest_out;
    endproperty
    property p_release_after;
        done |=> !done;
    endproperty
    property p_bad_addr;
        (avs_read_in && !avs_waitrequest_out && avs_address_in[1:0] != 2'h0)
            |-> (avs_response_out == 2'h3 && avs_readdata_out == 32'h0);
    endproperty
    a_pull_one_way: assert property (p_pull_one_way) else $error("pull both ways");
    a_pull_down_input: assert property (p_pull_down_input) else $error("pull down on output");
    a_no_pull_push_pull: assert property (p_no_pull_push_pull) else $error("pull on drive");
    a_drive_from_data: assert property (p_drive_from_data) else $error("drive without data");
    a_oe_output_only: assert property (p_oe_output_only) else $error("enable on input");
    a_reduced_output: assert property (p_reduced_output) else $error("reduced on input");
    a_one_wait: assert property (p_one_wait) else $error("wait not one cycle");
    a_release_after: assert property (p_release_after) else $error("double accept");
    a_bad_addr: assert property (p_bad_addr) else $error("bad address answered");
    c_read_done: cover property (avs_read_in && !avs_waitrequest_out);
    c_write_done: cover property (avs_write_in && !avs_waitrequest_out);
    c_pull_down: cover property (first_port_pad_out.pull_down != 6'h00);
endmodule : ppc_monitor
bind ppc_top ppc_monitor #(.M_PINS(M_PINS), .P_PINS(P_PINS)) u_mon (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_response_out(avs_response_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .first_port_direction_in(first_port_direction_in), .first_port_data_in(first_port_data_in),
    .periph_force_en_in(periph_force_en_in), .periph_force_dir_in(periph_force_dir_in),
    .first_port_pad_out(first_port_pad_out), .second_port_pad_out(second_port_pad_out));
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ppc_pkg::*;
;
    logic clk, rst_n, ce, rd, wr, wait_o;
    logic [7:0] adr, ext, short_low, p_pin;
    logic [3:0] be;
    logic [31:0] wdata, rdata, bus_d;
    logic [1:0] resp, bus_r;
    logic [5:0] m_dir, m_data, f_en, f_dir;
    ppc_m_pad_t m_pad;
    ppc_p_pad_t p_pad;
    int fail_count, checks;
    logic [7:0] rw_idx [5] = '{PPC_IDX_M_PULL_EN, PPC_IDX_M_PULL_POL, PPC_IDX_M_OPEN_DRAIN,
        PPC_IDX_P_DIR, PPC_IDX_P_DRIVE};
    ppc_top uut (.clk_sys_in(clk), .rst_n_in(rst_n), .ce_in(ce), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wdata),
        .avs_readdata_out(rdata), .avs_response_out(resp), .avs_waitrequest_out(wait_o),
        .first_port_direction_in(m_dir), .first_port_data_in(m_data),
        .periph_force_en_in(f_en), .periph_force_dir_in(f_dir), .first_port_pad_out(m_pad),
        .second_port_pin_in(p_pin), .second_port_pad_out(p_pad));
    ppc_pin_model u_pins (.pad_in(p_pad), .ext_level_in(ext), .short_low_in(short_low),
        .pin_out(p_pin));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wrap_up;
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] ba(input logic [7:0] idx);
        return idx << PPC_ADDR_SHIFT;
    endfunction : ba
    // Waitrequest and read data taken at the rising edge itself; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        adr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (wait_o !== 1'b0);
        bus_d = rdata;
        bus_r = resp;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] e,
        input logic [1:0] er);
        bus(1'b0, a, 8'h00);
        chk(name, {24'h0, e}, bus_d);
        chk({name, "_resp"}, {30'h0, er}, {30'h0, bus_r});
    endtask : rchk
    task automatic mcase(input logic [5:0] pe, pol, od, dir, dat, fe, fd);
        logic [5:0] d;
        ppc_m_pad_t e;
        d = (fe & fd) | (~fe & dir);
        e.oe = d & (~od | ~dat);
        e.drive = dat & ~od;
        e.pull_up = pe & ~pol & (~d | od);
        e.pull_down = pe & pol & ~d;
        bus(1'b1, ba(PPC_IDX_M_PULL_EN), {2'h0, pe});
        bus(1'b1, ba(PPC_IDX_M_PULL_POL), {2'h0, pol});
        bus(1'b1, ba(PPC_IDX_M_OPEN_DRAIN), {2'h0, od});
        m_dir <= dir;
        m_data <= dat;
        f_en <= fe;
        f_dir <= fd;
        repeat (2) @(posedge clk);
        chk("first_pad", {8'h0, e}, {8'h0, m_pad});
    endtask : mcase
    // ----------------------------------------
    // Clock, watchdog, tests
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
    initial begin
        {rst_n, rd, wr, adr, wdata, m_dir, m_data, f_en, f_dir, short_low} = '0;
        {ce, be, ext, fail_count, checks} = {1'b1, 4'h1, 8'ha5, 64'h0};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk("pull_en", ba(PPC_IDX_M_PULL_EN), 8'h3f, PPC_RESP_OKAY);
        rchk("pull_pol", ba(PPC_IDX_M_PULL_POL), 8'h00, PPC_RESP_OKAY);
        rchk("open_drain", ba(PPC_IDX_M_OPEN_DRAIN), 8'h00, PPC_RESP_OKAY);
        rchk("latch", ba(PPC_IDX_P_LATCH), 8'ha5, PPC_RESP_OKAY);
        rchk("levels", ba(PPC_IDX_P_LEVELS), 8'ha5, PPC_RESP_OKAY);
        rchk("dir", ba(PPC_IDX_P_DIR), 8'h00, PPC_RESP_OKAY);
        rchk("drive", ba(PPC_IDX_P_DRIVE), 8'h00, PPC_RESP_OKAY);
        chk("pull_up", 32'h3f, {26'h0, m_pad.pull_up});
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, ba(rw_idx[i]), 8'hc5);
            rchk("rw", ba(rw_idx[i]), (i < 3) ? 8'h05 : 8'hc5, PPC_RESP_OKAY);
        end
        bus(1'b1, ba(PPC_IDX_P_LEVELS), 8'hff);
        chk("ro_resp", 32'h0, {30'h0, bus_r});
        rchk("levels_ro", ba(PPC_IDX_P_LEVELS), 8'h20, PPC_RESP_OKAY);
        rchk("unmapped", 8'h7c, 8'h00, PPC_RESP_DECODE_ERR);
        rchk("misaligned", 8'h51, 8'h00, PPC_RESP_DECODE_ERR);
        bus(1'b1, 8'h7c, 8'hff);
        rchk("drive_kept", ba(PPC_IDX_P_DRIVE), 8'hc5, PPC_RESP_OKAY);
        bus(1'b1, ba(PPC_IDX_P_LATCH), 8'h3c);
        bus(1'b1, ba(PPC_IDX_P_DIR), 8'h0f);
        bus(1'b1, ba(PPC_IDX_P_DRIVE), 8'hff);
        // Lane 0 off: write accepted, nothing stored
        be <= 4'h0;
        bus(1'b1, ba(PPC_IDX_P_DRIVE), 8'h00);
        be <= 4'h1;
        rchk("lane_off", ba(PPC_IDX_P_DRIVE), 8'hff, PPC_RESP_OKAY);
        // Pad register plus synchroniser need a few cycles to settle
        repeat (4) @(posedge clk);
        rchk("mix", ba(PPC_IDX_P_LATCH), 8'hac, PPC_RESP_OKAY);
        rchk("pins", ba(PPC_IDX_P_LEVELS), 8'hac, PPC_RESP_OKAY);
        chk("oe", 32'h0f, {24'h0, p_pad.oe});
        chk("p_drive", 32'h3c, {24'h0, p_pad.drive});
        chk("reduced", 32'h0f, {24'h0, p_pad.reduced});
        short_low <= 8'h04;
        repeat (4) @(posedge clk);
        rchk("mix_short", ba(PPC_IDX_P_LATCH), 8'hac, PPC_RESP_OKAY);
        rchk("pins_short", ba(PPC_IDX_P_LEVELS), 8'ha8, PPC_RESP_OKAY);
        short_low <= 8'h00;
        bus(1'b1, ba(PPC_IDX_P_DIR), 8'hf0);
        repeat (4) @(posedge clk);
        rchk("mix_flip", ba(PPC_IDX_P_LATCH), 8'h35, PPC_RESP_OKAY);
        mcase(6'h3e, 6'h0c, 6'h2a, 6'h33, 6'h15, 6'h00, 6'h00);
        mcase(6'h3f, 6'h30, 6'h0f, 6'h0c, 6'h3f, 6'h03, 6'h01);
        mcase(6'h3f, 6'h30, 6'h0f, 6'h0c, 6'h3f, 6'h00, 6'h01);
        // Enable low freezes the pads
        ce <= 1'b0;
        m_data <= 6'h00;
        repeat (3) @(posedge clk);
        chk("frozen", 32'h30, {26'h0, m_pad.drive});
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        chk("thawed", 32'h00, {26'h0, m_pad.drive});
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
